// file: color_result_regs.vh
// Register indices, field positions, reset values and constants of the result and update bank.
`ifndef COLOR_RESULT_REGS_VH
`define COLOR_RESULT_REGS_VH

// Register indices; the APB byte address is four times the index.
`define IDX_TRI_X 8'h14
`define IDX_TRI_Y 8'h18
`define IDX_TRI_Z 8'h1c
`define IDX_C31_X 8'h20
`define IDX_C31_Y 8'h24
`define IDX_C76_UP 8'h28
`define IDX_C76_VP 8'h2c
`define IDX_C60_U 8'h30
`define IDX_C60_V 8'h34
`define IDX_DUV 8'h38
`define IDX_LUX_H 8'h3c
`define IDX_LUX_L 8'h3d
`define IDX_COLOUR_TEMP_HIGH_BYTE 8'h3e
`define IDX_COLOUR_TEMP_LOW_BYTE 8'h3f
`define IDX_UPD_CTRL 8'h48
`define IDX_CNT_H 8'h49
`define IDX_CNT_L 8'h4a
`define IDX_PAYLOAD 8'h4b
`define IDX_IRQ_STATUS 8'h4c
`define IDX_IRQ_MASK 8'h4d

// Address bus layout.
`define PADDR_W 10
`define IDX_MSB 9
`define IDX_LSB 2

// Control register bit positions.
`define CTL_START 7
`define CTL_STOP 6
`define CTL_DONE 5
`define CTL_LOCK 4
`define CTL_SWITCH 3
`define CTL_BANK_FIRST 2
`define CTL_ERROR 1
`define CTL_OTHER_IMAGE_VALID_FLAG 0

// Interrupt status bit positions.
`define IRQ_RESULT 0
`define IRQ_DONE 1
`define IRQ_ERROR 2
`define IRQ_W 3

// Image layout in flash.
`define IMAGE_SIZE 16'he000
`define BANK_FIRST_BASE 20'h12000
`define BANK_SECOND_BASE 20'h22000
`define FLASH_AW 20

// Reset values and the byte count increment.
`define RST_WORD 32'h00000000
`define RST_HALF 16'h0000
`define RST_BYTE 8'h00
`define RST_IRQ 3'h0
`define RST_BANK_FIRST 1'b1
`define CNT_ONE 16'h0001
`define SUM_ZERO 8'h00

`endif

// file: image_flash_writer.v
// One-byte holding stage that turns accepted image bytes into flash write requests.
`timescale 1ns/100ps
module image_flash_writer (
  input wire pclk,
  input wire presetn,
  input wire byte_valid,
  input wire [7:0] byte_data,
  input wire [15:0] byte_index,
  input wire to_first_bank,
  output wire byte_ready,
  output reg flash_wr_valid,
  output reg [19:0] flash_wr_addr,
  output reg [7:0] flash_wr_data,
  input wire flash_wr_ready
);
`include "color_result_regs.vh"

  wire [19:0] base_addr;

  assign base_addr = to_first_bank ? `BANK_FIRST_BASE : `BANK_SECOND_BASE;
  // Only one byte is held; the register side stalls a payload write while it is occupied.
  assign byte_ready = ~flash_wr_valid;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_wr_valid <= 1'b0;
      flash_wr_addr <= 20'h00000;
      flash_wr_data <= `RST_BYTE;
    end else if (byte_valid && byte_ready) begin
      flash_wr_valid <= 1'b1;
      flash_wr_addr <= base_addr + {4'h0, byte_index};
      flash_wr_data <= byte_data;
    end else if (flash_wr_valid && flash_wr_ready) begin
      flash_wr_valid <= 1'b0;
    end
  end
endmodule // image_flash_writer

// file: color_result_and_fw_update_regs.v
// APB register bank for colour results and the firmware image update port.
// Notes on behaviour
// - Tristimulus X, Y, Z read as 32-bit floats at 0x14, 0x18, 0x1C.
// - CIE 1931 x and y read as 32-bit floats at 0x20, 0x24.
// - CIE 1976 u', v' and CIE 1960 u, v read as 32-bit floats, 0x28 to 0x37.
// - Planckian distance reads as a 32-bit float at 0x38.
// - Illuminance 16-bit, high byte at 0x3C, low byte at 0x3D.
// - Colour temperature 16-bit, high byte at 0x3E, low byte at 0x3F.
// - Two flash images, based at 0x12000 and 0x22000.
// - A complete image is exactly 56k bytes.
// - Writing control bit 6 returns the update machine to idle.
// - Status bit 5 sets when the whole image has arrived.
// - Control bit 4 keeps the selected image for the next boot.
// - Writing control bit 3 outside an update, without bit 7, swaps the selected image bank.
// - Status bit 2 reads one while the first bank is active.
// - Status bit 1 sets when a payload write arrives while no update is accepting bytes.
// - Status bit 0 says the inactive bank has a valid checksum.
// - Byte count reads at 0x49 and 0x4A, zero after reset.
// - Each payload write at 0x4B during an update, before the image is complete, delivers the next image byte.
//
// Implementation choice: the APB register port.
`timescale 1ns/100ps
module color_result_and_fw_update_regs (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [9:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire result_load,
  input wire [31:0] tri_x_in,
  input wire [31:0] tri_y_in,
  input wire [31:0] tri_z_in,
  input wire [31:0] c31_x_in,
  input wire [31:0] c31_y_in,
  input wire [31:0] c76_up_in,
  input wire [31:0] c76_vp_in,
  input wire [31:0] c60_u_in,
  input wire [31:0] c60_v_in,
  input wire [31:0] duv_in,
  input wire [15:0] lux_in,
  input wire [15:0] cct_in,
  output wire flash_wr_valid,
  output wire [19:0] flash_wr_addr,
  output wire [7:0] flash_wr_data,
  input wire flash_wr_ready,
  output reg boot_lock,
  output reg boot_first_bank,
  output reg irq
);
`include "color_result_regs.vh"

  // Latched result words, indexed in register order from tristimulus X to planckian distance.
  reg [31:0] result_reg [0:9];
  reg [15:0] lux_reg;
  reg [15:0] cct_reg;
  reg update_mode_reg;
  reg complete_reg;
  reg lock_reg;
  reg first_active_reg;
  reg error_reg;
  reg chk_valid_reg;
  reg [15:0] count_reg;
  reg [7:0] payload_reg;
  reg [7:0] sum_reg;
  reg [`IRQ_W-1:0] irq_status_reg;
  reg [`IRQ_W-1:0] irq_mask_reg;
  reg [31:0] read_data;
  reg read_hit;
  reg [`IRQ_W-1:0] irq_status_next;

  wire [7:0] idx;
  wire access;
  wire commit;
  wire wr_commit;
  wire payload_wr;
  wire accept_ok;
  wire byte_accept;
  wire byte_ready;
  wire hold_bus;
  wire go;
  wire [15:0] count_next;
  wire [7:0] sum_next;
  wire image_done;
  wire byte_reject;
  wire ctl_wr;
  wire start_cmd;
  wire stop_cmd;
  wire switch_cmd;
  wire [31:0] result_in [0:9];
  reg [7:0] ctl_read;
  reg [`IRQ_W-1:0] irq_events;

  assign idx = paddr[`IDX_MSB:`IDX_LSB];
  assign access = psel & penable & ~pready;
  assign commit = psel & penable & pready;
  assign wr_commit = commit & pwrite;
  assign payload_wr = pwrite & (idx == `IDX_PAYLOAD);
  assign accept_ok = update_mode_reg & ~complete_reg;
  // A payload byte waits in the access phase until the flash stage can take it.
  assign hold_bus = payload_wr & accept_ok & ~byte_ready;
  assign go = access & ~hold_bus;

  assign byte_accept = wr_commit & (idx == `IDX_PAYLOAD) & accept_ok;
  assign byte_reject = wr_commit & (idx == `IDX_PAYLOAD) & ~accept_ok;
  assign count_next = count_reg + `CNT_ONE;
  assign sum_next = sum_reg + pwdata[7:0];
  assign image_done = byte_accept & (count_next == `IMAGE_SIZE);

  assign ctl_wr = wr_commit & (idx == `IDX_UPD_CTRL);
  assign stop_cmd = ctl_wr & pwdata[`CTL_STOP];
  assign start_cmd = ctl_wr & pwdata[`CTL_START] & ~pwdata[`CTL_STOP];
  // Swapping banks mid-transfer would split the image, so it is ignored during an update.
  assign switch_cmd = ctl_wr & pwdata[`CTL_SWITCH] & ~update_mode_reg & ~pwdata[`CTL_START];

  // Stop and switch are write-only strobes, so their bit positions read back as zero.
  always @* begin
    ctl_read = `RST_BYTE;
    ctl_read[`CTL_START] = update_mode_reg;
    ctl_read[`CTL_DONE] = complete_reg;
    ctl_read[`CTL_LOCK] = lock_reg;
    ctl_read[`CTL_BANK_FIRST] = first_active_reg;
    ctl_read[`CTL_ERROR] = error_reg;
    ctl_read[`CTL_OTHER_IMAGE_VALID_FLAG] = chk_valid_reg;
  end

  // Each event lands on its own status bit; a set beats a clear further down.
  always @* begin
    irq_events = `RST_IRQ;
    irq_events[`IRQ_RESULT] = result_load;
    irq_events[`IRQ_DONE] = image_done;
    irq_events[`IRQ_ERROR] = byte_reject;
  end

  // The stage sees the count before this byte, so the first byte lands at the bank base.
  // write to inactive bank
  image_flash_writer u_writer (
    .pclk(pclk),
    .presetn(presetn),
    .byte_valid(byte_accept),
    .byte_data(pwdata[7:0]),
    .byte_index(count_reg),
    .to_first_bank(~first_active_reg),
    .byte_ready(byte_ready),
    .flash_wr_valid(flash_wr_valid),
    .flash_wr_addr(flash_wr_addr),
    .flash_wr_data(flash_wr_data),
    .flash_wr_ready(flash_wr_ready)
  );

  // Unmapped indices answer with an error and read as zero.
  always @* begin
    read_data = `RST_WORD;
    read_hit = 1'b1;
    case (idx)
      `IDX_TRI_X: read_data = result_reg[0];
      `IDX_TRI_Y: read_data = result_reg[1];
      `IDX_TRI_Z: read_data = result_reg[2];
      `IDX_C31_X: read_data = result_reg[3];
      `IDX_C31_Y: read_data = result_reg[4];
      `IDX_C76_UP: read_data = result_reg[5];
      `IDX_C76_VP: read_data = result_reg[6];
      `IDX_C60_U: read_data = result_reg[7];
      `IDX_C60_V: read_data = result_reg[8];
      `IDX_DUV: read_data = result_reg[9];
      `IDX_LUX_H: read_data = {24'h000000, lux_reg[15:8]};
      `IDX_LUX_L: read_data = {24'h000000, lux_reg[7:0]};
      `IDX_COLOUR_TEMP_HIGH_BYTE: read_data = {24'h000000, cct_reg[15:8]};
      `IDX_COLOUR_TEMP_LOW_BYTE: read_data = {24'h000000, cct_reg[7:0]};
      `IDX_UPD_CTRL: read_data = {24'h000000, ctl_read};
      `IDX_CNT_H: read_data = {24'h000000, count_reg[15:8]};
      `IDX_CNT_L: read_data = {24'h000000, count_reg[7:0]};
      `IDX_PAYLOAD: read_data = {24'h000000, payload_reg};
      `IDX_IRQ_STATUS: read_data = {29'h0, irq_status_reg};
      `IDX_IRQ_MASK: read_data = {29'h0, irq_mask_reg};
      default: read_hit = 1'b0;
    endcase
  end

  // Bus answer: one wait state, more only while a payload byte is held back.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `RST_WORD;
    end else if (go) begin
      pready <= 1'b1;
      pslverr <= ~read_hit;
      prdata <= pwrite ? `RST_WORD : read_data;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Results are captured as a set so a read never mixes two measurements.
  // Input words in register order, so the capture loop below can index them.
  assign result_in[0] = tri_x_in;
  assign result_in[1] = tri_y_in;
  assign result_in[2] = tri_z_in;
  assign result_in[3] = c31_x_in;
  assign result_in[4] = c31_y_in;
  assign result_in[5] = c76_up_in;
  assign result_in[6] = c76_vp_in;
  assign result_in[7] = c60_u_in;
  assign result_in[8] = c60_v_in;
  assign result_in[9] = duv_in;

  genvar gi;
  generate
    for (gi = 0; gi < 10; gi = gi + 1) begin : g_result
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          result_reg[gi] <= `RST_WORD;
        end else if (result_load) begin
          result_reg[gi] <= result_in[gi];
        end
      end
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lux_reg <= `RST_HALF;
      cct_reg <= `RST_HALF;
    end else if (result_load) begin
      lux_reg <= lux_in;
      cct_reg <= cct_in;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      update_mode_reg <= 1'b0;
      complete_reg <= 1'b0;
      error_reg <= 1'b0;
      count_reg <= `RST_HALF;
      sum_reg <= `SUM_ZERO;
      chk_valid_reg <= 1'b0;
    end else if (stop_cmd) begin
      update_mode_reg <= 1'b0;
      complete_reg <= 1'b0;
      error_reg <= 1'b0;
      count_reg <= `RST_HALF;
      sum_reg <= `SUM_ZERO;
      chk_valid_reg <= 1'b0;
    end else if (start_cmd) begin
      update_mode_reg <= 1'b1;
      complete_reg <= 1'b0;
      error_reg <= 1'b0;
      count_reg <= `RST_HALF;
      sum_reg <= `SUM_ZERO;
      chk_valid_reg <= 1'b0;
    end else if (byte_accept) begin
      count_reg <= count_next;
      sum_reg <= sum_next;
      if (image_done) begin
        complete_reg <= 1'b1;
        chk_valid_reg <= (sum_next == `SUM_ZERO);
      end
    end else if (byte_reject) begin
      error_reg <= 1'b1;
    end else if (switch_cmd) begin
      // The image that becomes inactive has not been checked here.
      chk_valid_reg <= 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      payload_reg <= `RST_BYTE;
      lock_reg <= 1'b0;
      first_active_reg <= `RST_BANK_FIRST;
    end else begin
      if (wr_commit && (idx == `IDX_PAYLOAD)) begin
        payload_reg <= pwdata[7:0];
      end
      if (ctl_wr) begin
        lock_reg <= pwdata[`CTL_LOCK];
      end
      if (switch_cmd) begin
        first_active_reg <= ~first_active_reg;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_lock <= 1'b0;
      boot_first_bank <= `RST_BANK_FIRST;
    end else begin
      boot_lock <= lock_reg;
      boot_first_bank <= first_active_reg;
    end
  end

  // A fresh event beats a write-one-to-clear in the same cycle.
  always @* begin
    irq_status_next = irq_status_reg;
    if (wr_commit && (idx == `IDX_IRQ_STATUS)) begin
      irq_status_next = irq_status_reg & ~pwdata[`IRQ_W-1:0];
    end
    irq_status_next = irq_status_next | irq_events;
  end

  // The interrupt output lags status and mask by one clock, like boot_lock and boot_first_bank.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= `RST_IRQ;
      irq_mask_reg <= `RST_IRQ;
      irq <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      if (wr_commit && (idx == `IDX_IRQ_MASK)) begin
        irq_mask_reg <= pwdata[`IRQ_W-1:0];
      end
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end
endmodule // color_result_and_fw_update_regs

// file: color_result_regs_sva.sv
// Concurrent checks on the port behaviour of the result and image update register bank.
`timescale 1ns/100ps
module color_result_regs_sva (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [9:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire flash_wr_valid,
  input wire [19:0] flash_wr_addr,
  input wire [7:0] flash_wr_data,
  input wire flash_wr_ready,
  input wire boot_lock,
  input wire boot_first_bank
);
  wire [7:0] idx = paddr[9:2];
  wire mapped = (idx >= 8'h14 && idx <= 8'h38 && idx[1:0] == 2'b00) ||
    (idx >= 8'h3c && idx <= 8'h3f) || (idx >= 8'h48 && idx <= 8'h4d);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  a_ready_bound: assert property (s_setup ##1 s_access |-> ##[1:40] pready)
    else $error("transfer not answered in time");
  a_err_unmapped: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr does not match the address map");
  a_flash_hold: assert property (flash_wr_valid && !flash_wr_ready |=>
    flash_wr_valid && $stable(flash_wr_addr) && $stable(flash_wr_data))
    else $error("flash request changed before acceptance");
  a_flash_drop: assert property (flash_wr_valid && flash_wr_ready |=> !flash_wr_valid)
    else $error("flash request not released after acceptance");
  a_flash_bank: assert property (flash_wr_valid |->
    flash_wr_addr - (boot_first_bank ? 20'h22000 : 20'h12000) < 20'he000)
    else $error("flash address outside the inactive image");
  a_lock_copy: assert property (pready && pwrite && !pslverr && idx == 8'h48 |->
    ##2 boot_lock == $past(pwdata[4], 2))
    else $error("boot lock does not follow the control write");
endmodule // color_result_regs_sva
bind color_result_and_fw_update_regs color_result_regs_sva i_color_result_regs_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .flash_wr_valid(flash_wr_valid), .flash_wr_addr(flash_wr_addr),
  .flash_wr_data(flash_wr_data), .flash_wr_ready(flash_wr_ready),
  .boot_lock(boot_lock), .boot_first_bank(boot_first_bank));

// file: color_result_and_fw_update_regs_tb.sv
// Self-checking bench for the colour result and image update register bank.
`timescale 1ns/100ps
`include "color_result_regs.vh"
module color_result_and_fw_update_regs_tb;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [9:0] paddr = 10'h000;
  reg [31:0] pwdata = 32'h0;
  reg result_load = 1'b0;
  reg [31:0] res [0:9];
  reg [15:0] lux = 16'h0;
  reg [15:0] cct = 16'h0;
  reg flash_wr_ready = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, flash_wr_valid, boot_lock, boot_first_bank, irq;
  wire [19:0] flash_wr_addr;
  wire [7:0] flash_wr_data;
  integer fail_count = 0, checks_done = 0, mode = 0, errb = 0, first = 1, lock = 0, cnt = 0, k;
  reg [27:0] fq [$];
  reg [31:0] rd;
  reg err;
  reg [7:0] lastb;
  always #5 pclk = ~pclk;
  color_result_and_fw_update_regs i_color_result_and_fw_update_regs (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .result_load(result_load), .tri_x_in(res[0]), .tri_y_in(res[1]), .tri_z_in(res[2]),
    .c31_x_in(res[3]), .c31_y_in(res[4]), .c76_up_in(res[5]), .c76_vp_in(res[6]),
    .c60_u_in(res[7]), .c60_v_in(res[8]), .duv_in(res[9]), .lux_in(lux), .cct_in(cct),
    .flash_wr_valid(flash_wr_valid), .flash_wr_addr(flash_wr_addr),
    .flash_wr_data(flash_wr_data), .flash_wr_ready(flash_wr_ready), .boot_lock(boot_lock),
    .boot_first_bank(boot_first_bank), .irq(irq));
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    integer n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 60) begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1) begin
      fail_count++;
      finish_test;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input string what, input logic [7:0] idx, input logic [31:0] exp, input logic ee);
    apb(1'b0, idx, 32'h0);
    chk(what, exp, rd);
    chk("pslverr", {31'h0, ee}, {31'h0, err});
  endtask
  function logic [31:0] ctl_exp;
    return {24'h0, mode[0], 2'b00, lock[0], 1'b0, first[0], errb[0], 1'b0};
  endfunction
  // Control model; stop wins over start and a switch is ignored while updating.
  task ctl(input logic [7:0] v);
    apb(1'b1, `IDX_UPD_CTRL, {24'h0, v});
    lock = v[4];
    if (v[3] && !mode && !v[7]) first = !first;
    if (v[6] || v[7]) begin
      mode = v[6] ? 0 : 1;
      errb = 0;
      cnt = 0;
    end
  endtask
  task pay(input logic [7:0] b);
    apb(1'b1, `IDX_PAYLOAD, {24'h0, b});
    if (mode) begin
      fq.push_back({(first ? `BANK_SECOND_BASE : `BANK_FIRST_BASE) + cnt[19:0], b});
      cnt++;
      lastb = b;
    end else
      errb = 1;
  endtask
  task drain;
    k = 0;
    while (fq.size() > 0 && k < 200) begin
      @(posedge pclk);
      k++;
    end
    chk("flash_left", 0, fq.size());
  endtask
  // The flash side stalls at random so held requests are exercised.
  always @(posedge pclk) begin
    flash_wr_ready <= 1'($urandom);
    if (flash_wr_valid === 1'b1 && flash_wr_ready === 1'b1) begin
      if (fq.size() == 0) chk("flash_extra", 0, 1);
      else chk("flash", {4'h0, fq.pop_front()}, {4'h0, flash_wr_addr, flash_wr_data});
    end
  end
  initial begin
    void'($urandom(32'hbae9));
    for (k = 0; k < 10; k++) res[k] = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    chk("boot_first_bank", 1, boot_first_bank);
    rdc("ctrl", `IDX_UPD_CTRL, ctl_exp(), 1'b0);
    rdc("cnt_h", `IDX_CNT_H, 0, 1'b0);
    rdc("cnt_l", `IDX_CNT_L, 0, 1'b0);
    rdc("payload", `IDX_PAYLOAD, 0, 1'b0);
    @(posedge pclk);
    for (k = 0; k < 10; k++) res[k] <= $urandom;
    lux <= 16'($urandom);
    cct <= 16'($urandom);
    result_load <= 1'b1;
    @(posedge pclk);
    result_load <= 1'b0;
    for (k = 0; k < 10; k++) rdc("result", `IDX_TRI_X + 8'(4 * k), res[k], 1'b0);
    rdc("lux_h", `IDX_LUX_H, lux[15:8], 1'b0);
    rdc("lux_l", `IDX_LUX_L, lux[7:0], 1'b0);
    rdc("colour_temp_high_byte", `IDX_COLOUR_TEMP_HIGH_BYTE, cct[15:8], 1'b0);
    rdc("colour_temp_low_byte", `IDX_COLOUR_TEMP_LOW_BYTE, cct[7:0], 1'b0);
    apb(1'b1, `IDX_TRI_X, ~res[0]);
    rdc("ro_word", `IDX_TRI_X, res[0], 1'b0);
    rdc("unmapped", 8'h40, 0, 1'b1);
    rdc("status", `IDX_IRQ_STATUS, 1, 1'b0);
    chk("irq_masked", 0, irq);
    apb(1'b1, `IDX_IRQ_MASK, 32'h7);
    repeat (2) @(posedge pclk);
    chk("irq_on", 1, irq);
    apb(1'b1, `IDX_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq_off", 0, irq);
    pay(8'h5a);
    rdc("ctrl", `IDX_UPD_CTRL, ctl_exp(), 1'b0);
    rdc("status", `IDX_IRQ_STATUS, 4, 1'b0);
    chk("irq_err", 1, irq);
    apb(1'b1, `IDX_IRQ_STATUS, 32'h4);
    ctl(8'h40);
    rdc("ctrl", `IDX_UPD_CTRL, ctl_exp(), 1'b0);
    ctl(8'h80);
    for (k = 0; k < 6; k++) pay(8'($urandom));
    drain;
    rdc("cnt_h", `IDX_CNT_H, 0, 1'b0);
    rdc("cnt_l", `IDX_CNT_L, 6, 1'b0);
    rdc("payload", `IDX_PAYLOAD, lastb, 1'b0);
    ctl(8'h08);
    rdc("ctrl", `IDX_UPD_CTRL, ctl_exp(), 1'b0);
    ctl(8'h40);
    rdc("cnt_l", `IDX_CNT_L, 0, 1'b0);
    ctl(8'h08);
    rdc("ctrl", `IDX_UPD_CTRL, ctl_exp(), 1'b0);
    chk("boot_first_bank", 0, boot_first_bank);
    ctl(8'h10);
    rdc("ctrl", `IDX_UPD_CTRL, ctl_exp(), 1'b0);
    chk("boot_lock", 1, boot_lock);
    ctl(8'h80);
    for (k = 0; k < 2; k++) pay(8'($urandom));
    drain;
    rdc("cnt_l", `IDX_CNT_L, 2, 1'b0);
    finish_test;
  end
  initial begin
    #900000;
    fail_count++;
    finish_test;
  end
endmodule // color_result_and_fw_update_regs_tb
